// file: design/eisc_pkg.sv
// Constants and types shared by the external interrupt sensitivity block.
// Assumes an 8-bit register port and a single core clock.
`default_nettype none

package eisc_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_LINES = 4;
   localparam int FIELD_W   = 2;
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 2;
   localparam int NUM_SRC   = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_EDGE_CONFIG = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_PIN_SELECT  = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 2'h3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0]    EDGE_CONFIG_RST = 8'h00;
   localparam logic [DATA_W-1:0]    PIN_SELECT_RST  = 8'h00;
   localparam logic [NUM_LINES-1:0] IRQ_STATUS_RST  = 4'h0;
   localparam logic [NUM_LINES-1:0] IRQ_MASK_RST    = 4'h0;
   localparam logic [DATA_W-1:0]    RDATA_NONE      = 8'h00;

   // ----------------------------------------------------------------
   // Sensitivity modes, one per field
   // ----------------------------------------------------------------
   typedef enum logic [FIELD_W-1:0] {
      SENSE_FALL_LOW = 2'h0,
      SENSE_RISE     = 2'h1,
      SENSE_FALL     = 2'h2,
      SENSE_BOTH     = 2'h3
   } eisc_sense_e;

   // ----------------------------------------------------------------
   // Pin selection codes
   // ----------------------------------------------------------------
   localparam logic [FIELD_W-1:0] SEL_NONE  = 2'h0;
   localparam logic [FIELD_W-1:0] SEL_PIN_A = 2'h1;
   localparam logic [FIELD_W-1:0] SEL_PIN_B = 2'h2;
   localparam logic [FIELD_W-1:0] SEL_PIN_C = 2'h3;

   // ----------------------------------------------------------------
   // Port bit positions and synchronised source slots
   // ----------------------------------------------------------------
   localparam int PB0_BIT = 0;
   localparam int PB1_BIT = 1;
   localparam int PB2_BIT = 2;
   localparam int PB3_BIT = 3;
   localparam int PB5_BIT = 5;
   localparam int PB6_BIT = 6;
   localparam int PA7_BIT = 7;
   localparam int PA0_BIT = 0;

   localparam int SRC_PB0 = 0;
   localparam int SRC_PB1 = 1;
   localparam int SRC_PB2 = 2;
   localparam int SRC_PB3 = 3;
   localparam int SRC_PB5 = 4;
   localparam int SRC_PB6 = 5;
   localparam int SRC_PA7 = 6;
   localparam int SRC_PA0 = 7;

   localparam int LINE0 = 0;
   localparam int LINE1 = 1;
   localparam int LINE2 = 2;
   localparam int LINE3 = 3;

endpackage : eisc_pkg

`default_nettype wire

// file: design/eisc_edge.sv
// Two-stage synchroniser and edge finder for one external pin.
// Assumes the pin may change at any time relative to CLK.
`timescale 1ns/10ps
`default_nettype none

module eisc_edge
   import eisc_pkg::*;
(
   input  wire logic CLK,
   input  wire logic RESET,
   input  wire logic pin,
   output logic      rise,
   output logic      fall,
   output logic      low
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   // ----------------------------------------------------------------
   // Synchroniser; first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Idle high after reset so a held-high pin gives no false rise edge
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
   assign low  = ~sync_r;

endmodule : eisc_edge

`default_nettype wire

// file: design/eisc_sense.sv
// Sensitivity decode for one interrupt line.
// Assumes edge flags from a synchronised source and a valid connect flag.
`timescale 1ns/10ps
`default_nettype none

module eisc_sense
   import eisc_pkg::*;
(
   input  wire logic               connected,
   input  wire logic [FIELD_W-1:0] mode,
   input  wire logic               rise,
   input  wire logic               fall,
   input  wire logic               low,
   output logic                    event_hit
);

   logic hit;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   always_comb begin
      hit = 1'b0;
      case (eisc_sense_e'(mode))
         SENSE_FALL_LOW: hit = fall | low;
         SENSE_RISE:     hit = rise;
         SENSE_FALL:     hit = fall;
         SENSE_BOTH:     hit = rise | fall;
         default:        hit = 1'b0;
      endcase
   end

   assign event_hit = connected & hit;

endmodule : eisc_sense

`default_nettype wire

// file: design/eisc_top.sv
// External interrupt sensitivity controller, four lines, one level IRQ.
// Assumes a register port with one-cycle strobes and the core's I bit as an input.
`timescale 1ns/10ps
`default_nettype none

module eisc_top
   import eisc_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire logic [7:0]        PORT_A,
   input  wire logic [6:0]        PORT_B,
   input  wire logic              CORE_IMASK,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR_STB,
   input  wire logic              RD_STB,
   output logic      [DATA_W-1:0] RDATA,
   output logic      [NUM_LINES-1:0] LINE_PEND,
   output logic                   IRQ
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [DATA_W-1:0]    ext_irq_edge_config_r;
   logic [DATA_W-1:0]    ext_pin_select_reg_r;
   logic [NUM_LINES-1:0] irq_status_r;
   logic [NUM_LINES-1:0] irq_status_nxt;
   logic [NUM_LINES-1:0] irq_mask_r;
   logic [DATA_W-1:0]    rdata_r;
   logic [DATA_W-1:0]    rdata_nxt;
   logic                 irq_r;
   logic [NUM_LINES-1:0] line_pend_r;
   logic [NUM_LINES-1:0] pend_nxt;

   logic [NUM_SRC-1:0]   src_pin;
   logic [NUM_SRC-1:0]   src_rise;
   logic [NUM_SRC-1:0]   src_fall;
   logic [NUM_SRC-1:0]   src_low;

   logic [NUM_LINES-1:0] line_rise;
   logic [NUM_LINES-1:0] line_fall;
   logic [NUM_LINES-1:0] line_low;
   logic [NUM_LINES-1:0] line_conn;
   logic [NUM_LINES-1:0] line_event;

   logic [FIELD_W-1:0]   line3_sense_sel;
   logic [FIELD_W-1:0]   line2_sense_sel;
   logic [FIELD_W-1:0]   line1_sense_sel;
   logic [FIELD_W-1:0]   line0_sense_sel;
   logic [FIELD_W-1:0]   sel3;
   logic [FIELD_W-1:0]   sel2;
   logic [FIELD_W-1:0]   sel1;
   logic [FIELD_W-1:0]   sel0;
   logic [NUM_LINES-1:0][FIELD_W-1:0] line_mode;

   logic                 wr_edge_config;
   logic                 wr_pin_select;
   logic                 wr_irq_mask;
   logic                 cfg_wr_ok;
   logic                 rd_edge_config;
   logic                 rd_pin_select;
   logic                 rd_irq_status;
   logic                 rd_irq_mask;

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   assign line3_sense_sel = ext_irq_edge_config_r[LINE3*FIELD_W +: FIELD_W];
   assign line2_sense_sel = ext_irq_edge_config_r[LINE2*FIELD_W +: FIELD_W];
   assign line1_sense_sel = ext_irq_edge_config_r[LINE1*FIELD_W +: FIELD_W];
   assign line0_sense_sel = ext_irq_edge_config_r[LINE0*FIELD_W +: FIELD_W];

   // One mode per line, so the decode loop below indexes by line number
   assign line_mode = {line3_sense_sel, line2_sense_sel, line1_sense_sel, line0_sense_sel};

   assign sel3 = ext_pin_select_reg_r[LINE3*FIELD_W +: FIELD_W];
   assign sel2 = ext_pin_select_reg_r[LINE2*FIELD_W +: FIELD_W];
   assign sel1 = ext_pin_select_reg_r[LINE1*FIELD_W +: FIELD_W];
   assign sel0 = ext_pin_select_reg_r[LINE0*FIELD_W +: FIELD_W];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      wr_edge_config = 1'b0;
      wr_pin_select  = 1'b0;
      wr_irq_mask    = 1'b0;
      if (WR_STB && ADDR == ADDR_EDGE_CONFIG) begin
         wr_edge_config = 1'b1;
      end else if (WR_STB && ADDR == ADDR_PIN_SELECT) begin
         wr_pin_select = 1'b1;
      end else if (WR_STB && ADDR == ADDR_IRQ_MASK) begin
         wr_irq_mask = 1'b1;
      end
   end

   // Reads decoded once; the status clear and the read mux share them
   always_comb begin
      rd_edge_config = 1'b0;
      rd_pin_select  = 1'b0;
      rd_irq_status  = 1'b0;
      rd_irq_mask    = 1'b0;
      if (RD_STB && ADDR == ADDR_EDGE_CONFIG) begin
         rd_edge_config = 1'b1;
      end else if (RD_STB && ADDR == ADDR_PIN_SELECT) begin
         rd_pin_select = 1'b1;
      end else if (RD_STB && ADDR == ADDR_IRQ_STATUS) begin
         rd_irq_status = 1'b1;
      end else if (RD_STB && ADDR == ADDR_IRQ_MASK) begin
         rd_irq_mask = 1'b1;
      end
   end

   // A refused write leaves no trace; software sees it only by reading back
   assign cfg_wr_ok = wr_edge_config && CORE_IMASK;

   // ----------------------------------------------------------------
   // Source pins, each synchronised before selection
   // ----------------------------------------------------------------
   // Edges are found per pin, not per line, so changing the selection
   // never manufactures an edge out of two different pins.
   always_comb begin
      src_pin          = '0;
      src_pin[SRC_PB0] = PORT_B[PB0_BIT];
      src_pin[SRC_PB1] = PORT_B[PB1_BIT];
      src_pin[SRC_PB2] = PORT_B[PB2_BIT];
      src_pin[SRC_PB3] = PORT_B[PB3_BIT];
      src_pin[SRC_PB5] = PORT_B[PB5_BIT];
      src_pin[SRC_PB6] = PORT_B[PB6_BIT];
      src_pin[SRC_PA7] = PORT_A[PA7_BIT];
      src_pin[SRC_PA0] = PORT_A[PA0_BIT];
   end

   genvar gs;
   generate
      for (gs = 0; gs < NUM_SRC; gs = gs + 1) begin : g_src
         eisc_edge u_edge (
            .CLK   (CLK),
            .RESET (RESET),
            .pin   (src_pin[gs]),
            .rise  (src_rise[gs]),
            .fall  (src_fall[gs]),
            .low   (src_low[gs])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pin selection per line
   // ----------------------------------------------------------------
   always_comb begin
      line_rise = '0;
      line_fall = '0;
      line_low  = '0;
      line_conn = '0;
      // Line three: PB0 is its first pin; code zero connects no pin
      case (sel3)
         SEL_PIN_A: begin
            line_rise[LINE3] = src_rise[SRC_PB0];
            line_fall[LINE3] = src_fall[SRC_PB0];
            line_low[LINE3]  = src_low[SRC_PB0];
            line_conn[LINE3] = 1'b1;
         end
         SEL_PIN_B: begin
            line_rise[LINE3] = src_rise[SRC_PB1];
            line_fall[LINE3] = src_fall[SRC_PB1];
            line_low[LINE3]  = src_low[SRC_PB1];
            line_conn[LINE3] = 1'b1;
         end
         SEL_PIN_C: begin
            line_rise[LINE3] = src_rise[SRC_PB2];
            line_fall[LINE3] = src_fall[SRC_PB2];
            line_low[LINE3]  = src_low[SRC_PB2];
            line_conn[LINE3] = 1'b1;
         end
         default: line_conn[LINE3] = 1'b0;
      endcase
      // Line two: PB3 is its first pin; code zero connects no pin
      case (sel2)
         SEL_PIN_A: begin
            line_rise[LINE2] = src_rise[SRC_PB3];
            line_fall[LINE2] = src_fall[SRC_PB3];
            line_low[LINE2]  = src_low[SRC_PB3];
            line_conn[LINE2] = 1'b1;
         end
         SEL_PIN_B: begin
            line_rise[LINE2] = src_rise[SRC_PB5];
            line_fall[LINE2] = src_fall[SRC_PB5];
            line_low[LINE2]  = src_low[SRC_PB5];
            line_conn[LINE2] = 1'b1;
         end
         SEL_PIN_C: begin
            line_rise[LINE2] = src_rise[SRC_PB6];
            line_fall[LINE2] = src_fall[SRC_PB6];
            line_low[LINE2]  = src_low[SRC_PB6];
            line_conn[LINE2] = 1'b1;
         end
         default: line_conn[LINE2] = 1'b0;
      endcase
      // Lines one and zero have a single pin each; any non-zero code connects it
      if (sel1 != SEL_NONE) begin
         line_rise[LINE1] = src_rise[SRC_PA7];
         line_fall[LINE1] = src_fall[SRC_PA7];
         line_low[LINE1]  = src_low[SRC_PA7];
         line_conn[LINE1] = 1'b1;
      end
      if (sel0 != SEL_NONE) begin
         line_rise[LINE0] = src_rise[SRC_PA0];
         line_fall[LINE0] = src_fall[SRC_PA0];
         line_low[LINE0]  = src_low[SRC_PA0];
         line_conn[LINE0] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Sensitivity decode per line
   // ----------------------------------------------------------------
   genvar gl;
   generate
      for (gl = 0; gl < NUM_LINES; gl = gl + 1) begin : g_line
         eisc_sense u_sense (
            .connected (line_conn[gl]),
            .mode      (line_mode[gl]),
            .rise      (line_rise[gl]),
            .fall      (line_fall[gl]),
            .low       (line_low[gl]),
            .event_hit (line_event[gl])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sensitivity register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ext_irq_edge_config_r <= EDGE_CONFIG_RST;
      end else if (cfg_wr_ok) begin
         ext_irq_edge_config_r <= WDATA;
      end
   end

   // ----------------------------------------------------------------
   // Pin selection register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ext_pin_select_reg_r <= PIN_SELECT_RST;
      end else if (wr_pin_select) begin
         // Not gated by the core mask; only the sensitivity field is protected
         ext_pin_select_reg_r <= WDATA;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   // A new event in the cycle of the clearing read wins, so nothing is lost.
   // In level mode the bit simply re-sets every cycle the pin stays low.
   always_comb begin
      irq_status_nxt = irq_status_r;
      if (rd_irq_status) begin
         irq_status_nxt = '0;
      end
      irq_status_nxt = irq_status_nxt | line_event;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_status_r <= IRQ_STATUS_RST;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_mask_r <= IRQ_MASK_RST;
      end else if (wr_irq_mask) begin
         irq_mask_r <= WDATA[NUM_LINES-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   // Taken from the next status so the output does not lag the flag by a cycle
   assign pend_nxt = irq_status_nxt & irq_mask_r;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         line_pend_r <= IRQ_STATUS_RST;
         irq_r       <= 1'b0;
      end else begin
         line_pend_r <= pend_nxt;
         irq_r       <= |pend_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = RDATA_NONE;
      if (rd_edge_config) begin
         rdata_nxt = ext_irq_edge_config_r;
      end else if (rd_pin_select) begin
         rdata_nxt = ext_pin_select_reg_r;
      end else if (rd_irq_status) begin
         rdata_nxt = {{(DATA_W-NUM_LINES){1'b0}}, irq_status_r};
      end else if (rd_irq_mask) begin
         rdata_nxt = {{(DATA_W-NUM_LINES){1'b0}}, irq_mask_r};
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_r <= RDATA_NONE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign RDATA     = rdata_r;
   assign LINE_PEND = line_pend_r;
   assign IRQ       = irq_r;

endmodule : eisc_top

`default_nettype wire

// file: verification/eisc_top_props.sv
// Port-level checks for the external interrupt sensitivity controller.
// Assumes binding into eisc_top; sees only the top module's ports.
`timescale 1ns/10ps
`default_nettype none

module eisc_top_props
   import eisc_pkg::*;
(
   input wire logic                 CLK,
   input wire logic                 RESET,
   input wire logic [7:0]           PORT_A,
   input wire logic [6:0]           PORT_B,
   input wire logic                 CORE_IMASK,
   input wire logic [ADDR_W-1:0]    ADDR,
   input wire logic [DATA_W-1:0]    WDATA,
   input wire logic                 WR_STB,
   input wire logic                 RD_STB,
   input wire logic [DATA_W-1:0]    RDATA,
   input wire logic [NUM_LINES-1:0] LINE_PEND,
   input wire logic                 IRQ
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   AST_RST_CLEAR: assert property (disable iff (1'b0)
      $fell(RESET) |-> RDATA == RDATA_NONE && LINE_PEND == IRQ_STATUS_RST && !IRQ)
      else $error("outputs not clear after reset");
   AST_IRQ_LEVEL: assert property (IRQ == (|LINE_PEND))
      else $error("irq does not follow pending lines");
   AST_RDATA_IDLE: assert property (!$past(RD_STB) |-> RDATA == RDATA_NONE)
      else $error("read data outside read slot");
   AST_CFG_WRITE: assert property (
      (WR_STB && ADDR == ADDR_EDGE_CONFIG && CORE_IMASK) ##1 (RD_STB && ADDR == ADDR_EDGE_CONFIG)
      |=> RDATA == $past(WDATA, 2))
      else $error("edge config write not read back");
   AST_CFG_LOCK: assert property (
      (RD_STB && ADDR == ADDR_EDGE_CONFIG) ##1 (WR_STB && ADDR == ADDR_EDGE_CONFIG && !CORE_IMASK)
      ##1 (RD_STB && ADDR == ADDR_EDGE_CONFIG) |=> RDATA == $past(RDATA, 2))
      else $error("edge config changed while core mask clear");
   AST_SEL_RW: assert property (
      (WR_STB && ADDR == ADDR_PIN_SELECT) ##1 (RD_STB && ADDR == ADDR_PIN_SELECT)
      |=> RDATA == $past(WDATA, 2))
      else $error("pin select write not read back");
   AST_HI_ZERO: assert property (
      $past(RD_STB) && $past(ADDR) >= ADDR_IRQ_STATUS |-> RDATA[7:4] == 4'h0)
      else $error("upper status or mask bits not zero");
   AST_MASK_OFF: assert property (
      (WR_STB && ADDR == ADDR_IRQ_MASK && WDATA[3:0] == 4'h0) ##1 !(WR_STB && ADDR == ADDR_IRQ_MASK)
      |=> LINE_PEND == 4'h0)
      else $error("pending line seen with all masks clear");
endmodule : eisc_top_props

bind eisc_top eisc_top_props i_eisc_top_props (.CLK(CLK), .RESET(RESET), .PORT_A(PORT_A),
   .PORT_B(PORT_B), .CORE_IMASK(CORE_IMASK), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
   .RD_STB(RD_STB), .RDATA(RDATA), .LINE_PEND(LINE_PEND), .IRQ(IRQ));

`default_nettype wire

// file: verification/eisc_pins.sv
// Model of the external port pins that feed the interrupt lines.
// Assumes the caller invokes drive right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module eisc_pins
(
   output var logic [7:0] port_a,
   output var logic [6:0] port_b
);
   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   // Weak pull-ups keep every pin high while nothing drives it low
   initial begin
      port_a = 8'hff;
      port_b = 7'h7f;
   end

   task automatic drive(input logic on_b, input logic [2:0] idx, input logic lvl);
      if (on_b) begin
         port_b[idx] <= lvl;
      end else begin
         port_a[idx] <= lvl;
      end
   endtask : drive
endmodule : eisc_pins

`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the external interrupt sensitivity controller.
// Assumes the bound checker and the pin model beside the design.
`timescale 1ns/10ps
`default_nettype none

module tb
   import eisc_pkg::*;
;
   logic                 clk;
   logic                 reset;
   wire  logic [7:0]     port_a;
   wire  logic [6:0]     port_b;
   logic                 core_imask;
   logic [ADDR_W-1:0]    addr;
   logic [DATA_W-1:0]    wdata;
   logic                 wr_stb;
   logic                 rd_stb;
   logic [DATA_W-1:0]    rdata;
   logic [NUM_LINES-1:0] line_pend;
   logic                 irq;
   logic                 rd_d1 = 1'b0;
   logic [DATA_W-1:0]    exp_q;
   logic [DATA_W-1:0]    exp_d1;
   logic [7:0]           bit_l;
   logic [3:0]           pin_on_b = 4'b1100;
   logic [2:0]           pin_idx [4] = '{3'h0, 3'h7, 3'h3, 3'h0};
   int                   miscompares = 0;
   int                   n_tests = 0;
   int                   cycles = 0;

   eisc_top i_eisc_top (.CLK(clk), .RESET(reset), .PORT_A(port_a), .PORT_B(port_b),
      .CORE_IMASK(core_imask), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
      .RD_STB(rd_stb), .RDATA(rdata), .LINE_PEND(line_pend), .IRQ(irq));
   eisc_pins i_eisc_pins (.port_a(port_a), .port_b(port_b));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Strobes are left up so calls chain back to back; idle drops them
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      wr_stb <= 1'b1;
      rd_stb <= 1'b0;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      rd_stb <= 1'b1;
      wr_stb <= 1'b0;
      addr <= a;
      exp_q <= e;
      @(posedge clk);
   endtask : rd

   task automatic idle(input int n);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle

   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_d1) cmp(rdata, exp_d1);
      rd_d1 <= rd_stb;
      exp_d1 <= exp_q;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         report_and_stop;
      end
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      core_imask = 1'b0;
      addr = '0;
      wdata = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      exp_q = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_IRQ_STATUS, 8'h00);
      rd(ADDR_IRQ_MASK, 8'h00);
      rd(ADDR_PIN_SELECT, PIN_SELECT_RST);
      rd(ADDR_EDGE_CONFIG, EDGE_CONFIG_RST);
      wr(ADDR_EDGE_CONFIG, 8'ha5);
      rd(ADDR_EDGE_CONFIG, 8'h00);
      core_imask <= 1'b1;
      wr(ADDR_EDGE_CONFIG, 8'ha5);
      rd(ADDR_EDGE_CONFIG, 8'ha5);
      wr(ADDR_PIN_SELECT, 8'h55);
      rd(ADDR_PIN_SELECT, 8'h55);
      wr(ADDR_IRQ_MASK, 8'h0f);
      idle(6);
      cmp({4'h0, line_pend}, 8'h00);
      // Only the line under test has a nonzero field, so a misplaced field shows
      for (int l = 0; l < NUM_LINES; l++) begin
         for (int m = 0; m < 4; m++) begin
            bit_l = 8'h01 << l;
            wr(ADDR_EDGE_CONFIG, 8'(m << (2 * l)));
            idle(2);
            i_eisc_pins.drive(pin_on_b[l], pin_idx[l], 1'b0);
            idle(6);
            cmp({4'h0, line_pend}, (m != 1) ? bit_l : 8'h00);
            rd(ADDR_IRQ_STATUS, (m != 1) ? bit_l : 8'h00);
            idle(6);
            cmp({4'h0, line_pend}, (m == 0) ? bit_l : 8'h00);
            i_eisc_pins.drive(pin_on_b[l], pin_idx[l], 1'b1);
            idle(6);
            cmp({4'h0, line_pend}, (m != 2) ? bit_l : 8'h00);
            rd(ADDR_IRQ_STATUS, (m != 2) ? bit_l : 8'h00);
            idle(6);
            cmp({4'h0, line_pend}, 8'h00);
         end
      end
      wr(ADDR_EDGE_CONFIG, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h00);
      i_eisc_pins.drive(1'b0, 3'h0, 1'b0);
      idle(6);
      cmp({7'h0, irq}, 8'h00);
      rd(ADDR_IRQ_STATUS, 8'h01);
      i_eisc_pins.drive(1'b0, 3'h0, 1'b1);
      wr(ADDR_IRQ_MASK, 8'h0f);
      idle(6);
      cmp({7'h0, irq}, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h01);
      idle(6);
      cmp({7'h0, irq}, 8'h00);
      // Lines zero and one left unselected; lines two and three on their third pins
      wr(ADDR_PIN_SELECT, 8'hf0);
      wr(ADDR_EDGE_CONFIG, 8'hf0);
      i_eisc_pins.drive(1'b0, 3'h0, 1'b0);
      i_eisc_pins.drive(1'b1, 3'h2, 1'b0);
      idle(6);
      rd(ADDR_IRQ_STATUS, 8'h08);
      i_eisc_pins.drive(1'b1, 3'h6, 1'b0);
      idle(6);
      rd(ADDR_IRQ_STATUS, 8'h04);
      i_eisc_pins.drive(1'b0, 3'h0, 1'b1);
      i_eisc_pins.drive(1'b1, 3'h2, 1'b1);
      i_eisc_pins.drive(1'b1, 3'h6, 1'b1);
      idle(6);
      rd(ADDR_IRQ_STATUS, 8'h0c);
      // Middle codes move lines three and two to their second pins
      wr(ADDR_PIN_SELECT, 8'ha0);
      i_eisc_pins.drive(1'b1, 3'h1, 1'b0);
      idle(6);
      rd(ADDR_IRQ_STATUS, 8'h08);
      i_eisc_pins.drive(1'b1, 3'h5, 1'b0);
      idle(6);
      rd(ADDR_IRQ_STATUS, 8'h04);
      idle(2);
      report_and_stop;
   end
endmodule : tb

`default_nettype wire
